/* pkg/ehci_cap_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the capability parameter bank.
// Assumes: Byte addresses on an 8-bit Wishbone address, one aligned 32-bit word per register.
// Notes:   Definitions only.
`ifndef EHCI_CAP_CFG_SVH
`define EHCI_CAP_CFG_SVH

`define STRUCT_PARAMS_OFS 8'h04
`define CAP_PARAMS_OFS    8'h08
`define ROUTE_LO_OFS      8'h40
`define ROUTE_HI_OFS      8'h44
`define RELOAD_OFS        8'h4C

`define DBG_IDX_LSB       20
`define PORT_IND_BIT      16
`define CC_LSB            12
`define PCC_LSB           8
`define ROUTE_SEL_BIT     7
`define PWR_SW_BIT        4
`define PORTS_LSB         0
`define IST_LSB           4
`define PFL_BIT           1
`define WIDE_BIT          0
`define BUSY_BIT          8

`define RST_DBG_IDX       4'h0
`define RST_PORT_IND      1'b0
`define RST_CC            4'h2
`define RST_PCC           4'h2
`define RST_ROUTE_SEL     1'b0
`define RST_PWR_SW        1'b1
`define RST_PORTS         4'h4
`define RST_IST           4'h1
`define RST_PFL           1'b1
`define RST_WIDE          1'b0

`define MAX_PORTS         15
`define SYNC_FILL_CYCLES  2'h3

`endif

/* pkg/ehci_cap_pkg.sv */
// Purpose: Types shared by the capability parameter bank.
// Assumes: Field widths as laid out in the structural and capability words.
// Notes:   Constants live in ehci_cap_cfg.svh.
package ehci_cap_pkg;

  typedef struct packed {
    logic [3:0] debug_port_index;
    logic       port_indicator;
    logic [3:0] companion_count;
    logic [3:0] ports_per_companion;
    logic       routing_rule_select;
    logic       port_power_switch_present;
    logic [3:0] port_count;
  } structural_t;

  typedef struct packed {
    logic [3:0] iso_schedule_threshold;
    logic       programmable_frame_list;
    logic       wide_address_capable;
  } capability_t;

  typedef struct packed {
    logic route_clamped;
    logic debug_cleared;
    logic pcc_adjusted;
    logic ports_forced;
  } fixup_t;

  typedef logic [14:0][3:0] route_tab_t;

  typedef enum logic [2:0] {
    ST_FILL = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN  = 3'b100
  } load_state_t;

endpackage

/* rtl/ehci_capability_params.sv */
// Purpose: Read-only structural and capability parameter words behind a Wishbone slave.
// Assumes: Straps are pin levels; the route table and capability bits are build parameters.
// Notes:   Strap values are cleaned up before they are shown, so software never sees an illegal mix.
//
// Behaviour
// - Zero companion count means no companions, no hand-off, high-speed only.
// - Nonzero companion count means companions present and port hand-off supported.
// - Ports-per-companion field reports ports per companion, consistent with port and companion counts.
// - Routing bit 0 maps consecutive port groups to companions in ascending order.
// - Routing bit 1 takes each port's companion from its route table entry, clamping entries past the last companion to the last companion.
// - Power switch bit 4 reads 1 with port power switches, else 0.
// - Power switch bit governs port power field behaviour in every port register.
// - Port count bits 3..0 give physical ports and addressable per-port registers.
// - Port count always reads 1h through Fh, never zero.
// - Capability word is a 32-bit register at offset 08h.
// - Debug port index never exceeds port count; nonzero marks debug port.
`timescale 1ns/1ns
`include "ehci_cap_cfg.svh"
module ehci_capability_params
  import ehci_cap_pkg::*;
#(
  parameter route_tab_t ROUTE_TABLE    = '0,
  parameter logic [3:0] ISO_THRESHOLD  = `RST_IST,
  parameter logic       PROG_FRAME     = `RST_PFL,
  parameter logic       WIDE_ADDRESS   = `RST_WIDE,
  parameter logic       PORT_INDICATOR = `RST_PORT_IND
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Configuration straps
  input  wire logic [3:0]  strap_port_count,
  input  wire logic [3:0]  strap_companion_count,
  input  wire logic [3:0]  strap_ports_per_companion,
  input  wire logic        strap_routing_rule_select,
  input  wire logic        strap_power_switch,
  input  wire logic [3:0]  strap_debug_port_index,
  // Derived configuration
  output logic             handoff_supported,
  output logic             high_speed_only,
  output logic             port_power_software_ctrl,
  output logic [14:0]      port_present_mask,
  output route_tab_t       port_owner,
  output logic             config_valid
);

  ////////////////////////////////////////////////////////////////////////////////
  // Strap synchronisation

  logic [17:0] strap_sync_w;
  structural_t strap_w;
  strap_sync #(
    .WIDTH    (18)
  ) u_strap_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({strap_debug_port_index, strap_companion_count, strap_ports_per_companion,
                strap_routing_rule_select, strap_power_switch, strap_port_count}),
    .sync_out (strap_sync_w)
  );

  assign strap_w = '{debug_port_index: strap_sync_w[17:14], port_indicator: PORT_INDICATOR,
                     companion_count: strap_sync_w[13:10], ports_per_companion: strap_sync_w[9:6],
                     routing_rule_select: strap_sync_w[5], port_power_switch_present: strap_sync_w[4],
                     port_count: strap_sync_w[3:0]};

  ////////////////////////////////////////////////////////////////////////////////
  // Clean-up of the strapped structure

  structural_t nxt_hcs;
  fixup_t      nxt_fix;
  logic [7:0]  pcc_cover;

  always_comb
  begin
    nxt_hcs   = strap_w;
    nxt_fix   = '0;
    pcc_cover = 8'h00;
    if (strap_w.port_count == 4'h0)
    begin
      nxt_hcs.port_count   = 4'h1;
      nxt_fix.ports_forced = 1'b1;
    end
    if (strap_w.companion_count == 4'h0)
    begin
      nxt_hcs.ports_per_companion = 4'h0;
      nxt_hcs.routing_rule_select = 1'b0;
    end
    else
    begin
      pcc_cover = {4'h0, strap_w.ports_per_companion} * {4'h0, strap_w.companion_count};
      if ((strap_w.ports_per_companion == 4'h0) || (strap_w.ports_per_companion > nxt_hcs.port_count)
          || (pcc_cover < {4'h0, nxt_hcs.port_count}))
      begin
        // One companion taking every port is always a consistent fallback.
        nxt_hcs.ports_per_companion = nxt_hcs.port_count;
        nxt_fix.pcc_adjusted        = 1'b1;
      end
    end
    if (strap_w.debug_port_index > nxt_hcs.port_count)
    begin
      nxt_hcs.debug_port_index = 4'h0;
      nxt_fix.debug_cleared    = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-port routing

  function automatic logic [3:0] group_of(input int idx, input logic [3:0] pcc);
    logic [3:0] grp;
    logic [3:0] cnt;
    grp = 4'h0;
    cnt = 4'h0;
    for (int k = 0; k < `MAX_PORTS; k++)
    begin
      if (k < idx)
      begin
        cnt = cnt + 4'h1;
        if (cnt == pcc)
        begin
          cnt = 4'h0;
          grp = grp + 4'h1;
        end
      end
    end
    return grp;
  endfunction

  route_tab_t  nxt_route;
  route_tab_t  nxt_owner;
  logic [14:0] nxt_mask;
  logic [14:0] clamp_hit;

  genvar gi;
  generate
    for (gi = 0; gi < `MAX_PORTS; gi++)
    begin : g_port
      always_comb
      begin
        nxt_route[gi] = 4'h0;
        nxt_owner[gi] = 4'h0;
        clamp_hit[gi] = 1'b0;
        nxt_mask[gi]  = (4'(gi) < nxt_hcs.port_count);
        if (nxt_mask[gi] && (nxt_hcs.companion_count != 4'h0))
        begin
          nxt_route[gi] = ROUTE_TABLE[gi];
          if (ROUTE_TABLE[gi] >= nxt_hcs.companion_count)
          begin
            nxt_route[gi] = nxt_hcs.companion_count - 4'h1;
            clamp_hit[gi] = nxt_hcs.routing_rule_select;
          end
          if (nxt_hcs.routing_rule_select)
          begin
            nxt_owner[gi] = nxt_route[gi];
          end
          else
          begin
            nxt_owner[gi] = group_of(gi, nxt_hcs.ports_per_companion);
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Load sequencing

  load_state_t state_ff;
  logic [1:0]  fill_cnt_ff;
  logic        reload_req;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff    <= ST_FILL;
      fill_cnt_ff <= 2'h0;
    end
    else
    begin
      case (state_ff)
        ST_FILL:
        begin
          // Wait until the synchroniser holds fresh strap levels.
          fill_cnt_ff <= fill_cnt_ff + 2'h1;
          if (fill_cnt_ff == (`SYNC_FILL_CYCLES - 2'h1))
          begin
            state_ff    <= ST_LOAD;
            fill_cnt_ff <= 2'h0;
          end
        end
        ST_LOAD:
        begin
          state_ff <= ST_RUN;
        end
        ST_RUN:
        begin
          if (reload_req)
          begin
            state_ff <= ST_FILL;
          end
        end
        default:
        begin
          state_ff    <= ST_FILL;
          fill_cnt_ff <= 2'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter registers

  structural_t hcs_ff;
  fixup_t      fix_ff;
  route_tab_t  route_ff;
  route_tab_t  owner_ff;
  logic [14:0] mask_ff;
  logic        handoff_ff;
  logic        hs_only_ff;
  logic        pwr_ctrl_ff;
  logic        valid_ff;
  capability_t hcc_w;

  assign hcc_w = '{iso_schedule_threshold: ISO_THRESHOLD,
                   programmable_frame_list: PROG_FRAME,
                   wide_address_capable: WIDE_ADDRESS};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hcs_ff <= '{debug_port_index: `RST_DBG_IDX, port_indicator: `RST_PORT_IND,
                  companion_count: `RST_CC, ports_per_companion: `RST_PCC,
                  routing_rule_select: `RST_ROUTE_SEL, port_power_switch_present: `RST_PWR_SW,
                  port_count: `RST_PORTS};
      fix_ff <= '0;
    end
    else if (state_ff == ST_LOAD)
    begin
      hcs_ff <= nxt_hcs;
      fix_ff <= '{route_clamped: |clamp_hit, debug_cleared: nxt_fix.debug_cleared,
                  pcc_adjusted: nxt_fix.pcc_adjusted, ports_forced: nxt_fix.ports_forced};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      route_ff    <= '0;
      owner_ff    <= '0;
      mask_ff     <= 15'h0000;
      handoff_ff  <= 1'b0;
      hs_only_ff  <= 1'b0;
      pwr_ctrl_ff <= 1'b0;
      valid_ff    <= 1'b0;
    end
    else if (state_ff == ST_LOAD)
    begin
      route_ff    <= nxt_route;
      owner_ff    <= nxt_owner;
      mask_ff     <= nxt_mask;
      handoff_ff  <= (nxt_hcs.companion_count != 4'h0);
      hs_only_ff  <= (nxt_hcs.companion_count == 4'h0);
      pwr_ctrl_ff <= nxt_hcs.port_power_switch_present;
      valid_ff    <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  logic        ack_ff;
  logic [31:0] dat_ff;
  logic        req_new;
  logic [31:0] nxt_dat;

  assign req_new = wb_cyc_i && wb_stb_i && !ack_ff;
  // Writes land on the edge that completes the cycle; only the reload word listens.
  assign reload_req = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && (wb_adr_i == `RELOAD_OFS)
                      && wb_sel_i[0] && wb_dat_i[0];

  always_comb
  begin
    nxt_dat = 32'h0000_0000;
    case (wb_adr_i)
      `STRUCT_PARAMS_OFS:
      begin
        nxt_dat[`DBG_IDX_LSB+:4] = hcs_ff.debug_port_index;
        nxt_dat[`PORT_IND_BIT]   = hcs_ff.port_indicator;
        nxt_dat[`CC_LSB+:4]      = hcs_ff.companion_count;
        nxt_dat[`PCC_LSB+:4]     = hcs_ff.ports_per_companion;
        nxt_dat[`ROUTE_SEL_BIT]  = hcs_ff.routing_rule_select;
        nxt_dat[`PWR_SW_BIT]     = hcs_ff.port_power_switch_present;
        nxt_dat[`PORTS_LSB+:4]   = hcs_ff.port_count;
      end
      `CAP_PARAMS_OFS:
      begin
        nxt_dat[`IST_LSB+:4] = hcc_w.iso_schedule_threshold;
        nxt_dat[`PFL_BIT]    = hcc_w.programmable_frame_list;
        nxt_dat[`WIDE_BIT]   = hcc_w.wide_address_capable;
      end
      `ROUTE_LO_OFS:
      begin
        nxt_dat = route_ff[7:0];
      end
      `ROUTE_HI_OFS:
      begin
        nxt_dat[27:0] = route_ff[14:8];
      end
      `RELOAD_OFS:
      begin
        nxt_dat[3:0]       = fix_ff;
        nxt_dat[`BUSY_BIT] = (state_ff != ST_RUN);
      end
      default:
      begin
        nxt_dat = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= req_new;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dat_ff <= 32'h0000_0000;
    end
    else if (req_new && !wb_we_i)
    begin
      dat_ff <= nxt_dat;
    end
  end

  assign wb_dat_o                 = dat_ff;
  assign wb_ack_o                 = ack_ff;
  assign handoff_supported        = handoff_ff;
  assign high_speed_only          = hs_only_ff;
  assign port_power_software_ctrl = pwr_ctrl_ff;
  assign port_present_mask        = mask_ff;
  assign port_owner               = owner_ff;
  assign config_valid             = valid_ff;

endmodule

/* rtl/strap_sync.sv */
// Purpose: Two-stage synchroniser for a vector of slow strap levels.
// Assumes: Straps are static or change only rarely, so bits need not arrive together.
// Notes:   The first stage feeds only the second.
`timescale 1ns/1ns
module strap_sync
#(
  parameter int WIDTH = 18
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

/* verification/ehci_capability_params_properties.sv */
// Purpose: Concurrent checks on the capability parameter bank ports.
// Assumes: Default build parameters, one clock, synchronous active-high reset.
// Notes:   Attached by bind at the foot of this file.
`timescale 1ns/1ns
`include "ehci_cap_cfg.svh"
module ehci_capability_params_properties
  import ehci_cap_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Derived configuration
  input wire logic        handoff_supported,
  input wire logic        high_speed_only,
  input wire logic        port_power_software_ctrl,
  input wire logic [14:0] port_present_mask,
  input wire route_tab_t  port_owner,
  input wire logic        config_valid
);
  logic rd_done;
  assign rd_done = wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_timing_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not answered");
  cap_word_a:
    assert property (rd_done && wb_adr_i == `CAP_PARAMS_OFS |->
      wb_dat_o == {24'h000000, `RST_IST, 2'b00, `RST_PFL, `RST_WIDE}) else $error("capability word wrong");
  struct_rsvd_a:
    assert property (rd_done && wb_adr_i == `STRUCT_PARAMS_OFS |-> (wb_dat_o & 32'hFF0E0060) == 32'h0)
      else $error("reserved bits not zero");
  ports_valid_a:
    assert property (rd_done && wb_adr_i == `STRUCT_PARAMS_OFS |-> wb_dat_o[3:0] != 4'h0)
      else $error("port count zero");
  debug_bound_a:
    assert property (rd_done && wb_adr_i == `STRUCT_PARAMS_OFS |-> wb_dat_o[23:20] <= wb_dat_o[3:0])
      else $error("debug index above port count");
  pcc_fit_a:
    assert property (rd_done && wb_adr_i == `STRUCT_PARAMS_OFS && wb_dat_o[15:12] != 4'h0 |->
      wb_dat_o[11:8] != 4'h0 && wb_dat_o[11:8] <= wb_dat_o[3:0]
      && ({4'h0, wb_dat_o[11:8]} * {4'h0, wb_dat_o[15:12]}) >= {4'h0, wb_dat_o[3:0]})
      else $error("ports per companion inconsistent");
  power_tie_a:
    assert property (rd_done && wb_adr_i == `STRUCT_PARAMS_OFS && $past(config_valid) |->
      wb_dat_o[4] == $past(port_power_software_ctrl)) else $error("power switch bit disagrees");
  handoff_a:
    assert property (config_valid |-> handoff_supported != high_speed_only) else $error("handoff flags clash");
  hs_owner_a:
    assert property (config_valid && high_speed_only |-> port_owner == '0) else $error("owner without companion");
  mask_shape_a:
    assert property (config_valid |-> port_present_mask[0] && ((port_present_mask + 15'h1) & port_present_mask) == 0)
      else $error("port mask not contiguous");
endmodule
bind ehci_capability_params ehci_capability_params_properties i_props (.clk(clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .handoff_supported(handoff_supported), .high_speed_only(high_speed_only),
  .port_power_software_ctrl(port_power_software_ctrl), .port_present_mask(port_present_mask),
  .port_owner(port_owner), .config_valid(config_valid));

/* verification/ehci_capability_params_tb_top.sv */
// Purpose: Self-checking bench for the capability parameter bank.
// Assumes: Route table built as entry i = i mod 4; other parameters default.
// Notes:   Straps are reloaded through the reload word before each configuration check.
`timescale 1ns/1ns
`include "ehci_cap_cfg.svh"
module ehci_capability_params_tb_top
  import ehci_cap_pkg::*;
;
  logic        clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, s_ports, s_cc, s_pcc, s_dbg;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        s_route, s_pwr, handoff_supported, high_speed_only, port_power_software_ctrl, config_valid;
  logic [14:0] port_present_mask;
  route_tab_t  port_owner;
  int          error_cnt, total_checks;
  ehci_capability_params #(.ROUTE_TABLE(60'h210321032103210)) i_dut (.clk(clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .strap_port_count(s_ports),
    .strap_companion_count(s_cc), .strap_ports_per_companion(s_pcc), .strap_routing_rule_select(s_route),
    .strap_power_switch(s_pwr), .strap_debug_port_index(s_dbg), .handoff_supported(handoff_supported),
    .high_speed_only(high_speed_only), .port_power_software_ctrl(port_power_software_ctrl),
    .port_present_mask(port_present_mask), .port_owner(port_owner), .config_valid(config_valid));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // The request is held until ack is sampled, so a slow slave never sees a torn cycle.
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= 4'hF;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    chk(n, 32'h2, "ack latency");
  endtask
  function automatic logic [31:0] exp_word(input logic [3:0] p, c, q, input logic r, w, input logic [3:0] d);
    if (p == 4'h0) p = 4'h1;
    if (c == 4'h0)
    begin
      q = 4'h0;
      r = 1'b0;
    end
    else if (q == 4'h0 || q > p || ({4'h0, q} * {4'h0, c}) < {4'h0, p}) q = p;
    if (d > p) d = 4'h0;
    return {8'h00, d, 4'h0, c, q, r, 2'b00, w, p};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_config(input logic [3:0] p, c, q, input logic r, w, input logic [3:0] d);
    logic [31:0] rd, ew;
    logic [14:0] m;
    logic [3:0]  e;
    logic [3:0]  fx;
    logic        rc;
    int n;
    @(posedge clk);
    s_ports <= p; s_cc <= c; s_pcc <= q; s_route <= r; s_pwr <= w; s_dbg <= d;
    repeat (3) @(posedge clk);
    wb_xfer(1'b1, `RELOAD_OFS, 32'h1, rd);
    n = 0;
    do
    begin
      wb_xfer(1'b0, `RELOAD_OFS, 32'h0, rd);
      n++;
    end while (rd[`BUSY_BIT] !== 1'b0 && n < 10);
    chk(rd[`BUSY_BIT], 1'b0, "reload busy");
    fx = rd[3:0];
    ew = exp_word(p, c, q, r, w, d);
    rc = 1'b0;
    wb_xfer(1'b0, `STRUCT_PARAMS_OFS, 32'h0, rd);
    chk(rd, ew, "structural word");
    chk(handoff_supported, c != 4'h0, "handoff");
    chk(high_speed_only, c == 4'h0, "high speed only");
    chk(port_power_software_ctrl, w, "power control");
    chk(config_valid, 1'b1, "config valid");
    for (int i = 0; i < 15; i++) m[i] = (i < ew[3:0]);
    chk(port_present_mask, m, "port mask");
    for (int i = 0; i < 15; i++)
    begin
      e = 4'h0;
      if (i < ew[3:0] && c != 4'h0) e = r ? (((i % 4) > c - 1) ? c - 1 : i % 4) : i / ew[11:8];
      if (r && c != 4'h0 && i < ew[3:0] && (i % 4) >= c) rc = 1'b1;
      chk(port_owner[i], e, "port owner");
    end
    chk(fx, {rc, ew[23:20] != d, c != 4'h0 && ew[11:8] != q, p == 4'h0}, "fixup flags");
    $display("config test done ports %0d companions %0d", p, c);
  endtask
  // Writes land on the structural, capability and low route words and one unmapped address; a bank that latches any of them fails here.
  task automatic t_write_ignored;
    logic [31:0] rd;
    wb_xfer(1'b1, `STRUCT_PARAMS_OFS, 32'hFFFFFFFF, rd);
    wb_xfer(1'b1, `CAP_PARAMS_OFS, 32'hFFFFFFFF, rd);
    wb_xfer(1'b1, 8'h10, 32'hFFFFFFFF, rd);
    wb_xfer(1'b1, `ROUTE_LO_OFS, 32'hFFFFFFFF, rd);
    wb_xfer(1'b0, `STRUCT_PARAMS_OFS, 32'h0, rd);
    chk(rd, exp_word(4'h4, 4'h2, 4'h2, 1'b0, 1'b1, 4'h0), "structural after write");
    wb_xfer(1'b0, `CAP_PARAMS_OFS, 32'h0, rd);
    chk(rd, {24'h000000, `RST_IST, 2'b00, `RST_PFL, `RST_WIDE}, "capability word");
    wb_xfer(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    wb_xfer(1'b0, `ROUTE_LO_OFS, 32'h0, rd);
    chk(rd, 32'h00001110, "route word");
    wb_xfer(1'b0, 8'h0A, 32'h0, rd);
    chk(rd, 32'h0, "misaligned read");
    $display("write ignore test done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
  initial
  begin
    error_cnt = 0; total_checks = 0; rst = 1'b1;
    wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 8'h00; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
    s_ports = 4'h4; s_cc = 4'h2; s_pcc = 4'h2; s_route = 1'b0; s_pwr = 1'b1; s_dbg = 4'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_config(4'h0, 4'h0, 4'h3, 1'b1, 1'b0, 4'h5);
    t_config(4'hF, 4'h3, 4'h5, 1'b1, 1'b1, 4'hF);
    t_config(4'h6, 4'h2, 4'h1, 1'b0, 1'b1, 4'h7);
    t_config(4'h3, 4'h4, 4'h1, 1'b1, 1'b0, 4'h3);
    t_config(4'h4, 4'h2, 4'h2, 1'b0, 1'b1, 4'h0);
    t_write_ignored();
    complete_run();
  end
endmodule
